/* File: src/gpio_port_pin_logic.sv */
// Purpose: port 7 three-pin general-purpose I/O logic
// Assumes: pins and peripheral enables from outside, pins asynchronous and synchronised here in two stages
// Notes: standby mode arrives as a level from the power controller
`timescale 1ns/100ps
module gpio_port_pin_logic (
    input  wire logic                                 mclk,
    input  wire logic                                 arst_n,
    input  wire logic [gpio_port_pkg::AW-1:0]         regAddr,
    input  wire logic [gpio_port_pkg::DW-1:0]         regWdata,
    input  wire logic                                 regWrite,
    input  wire logic                                 regRead,
    input  wire logic                                 regRmw,
    output logic      [gpio_port_pkg::DW-1:0]         regRdata,
    input  wire logic [gpio_port_pkg::NPINS-1:0]      pinIn,
    output logic      [gpio_port_pkg::NPINS-1:0]      pinOut,
    output logic      [gpio_port_pkg::NPINS-1:0]      pinOe,
    output logic      [gpio_port_pkg::NPINS-1:0]      pullupOn,
    input  wire logic [gpio_port_pkg::NPINS-1:0]      periphOe,
    input  wire logic [gpio_port_pkg::NPINS-1:0]      periphOut,
    output logic      [gpio_port_pkg::NPINS-1:0]      periphIn,
    input  wire logic [gpio_port_pkg::NPINS-1:0]      analogShared,
    input  wire logic [gpio_port_pkg::NPINS-1:0]      keepInputAwake,
    input  wire logic                                 stopOrWatch
);
    import gpio_port_pkg::*;

    // ----------------------------------------
    // registers
    // ----------------------------------------
    logic [NPINS-1:0] port7_data_latch;
    logic [NPINS-1:0] port7_direction;
    logic [NPINS-1:0] port7_pullup_enable;
    logic [NPINS-1:0] analog_input_disable_upper;
    logic             standby_pin_state_select;
    logic [NPINS-1:0] pinMeta;
    logic [NPINS-1:0] pinSync;

    wire wrData  = regWrite && regAddr == ADDR_DATA;
    wire wrDir   = regWrite && regAddr == ADDR_DIR;
    wire wrPull  = regWrite && regAddr == ADDR_PULLUP;
    wire wrAdis  = regWrite && regAddr == ADDR_ANALOG_DIS;
    wire wrStby  = regWrite && regAddr == ADDR_STANDBY;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            port7_data_latch           <= PIN_RESET;
            port7_direction            <= PIN_RESET;
            port7_pullup_enable        <= PIN_RESET;
            analog_input_disable_upper <= PIN_RESET;
            standby_pin_state_select   <= 1'b0;
        end else begin
            // only low three bits stored (bit 0 alone for the standby select), upper bits dropped
            if (wrData) port7_data_latch <= regWdata[NPINS-1:0];
            if (wrDir)  port7_direction <= regWdata[NPINS-1:0];
            if (wrPull) port7_pullup_enable <= regWdata[NPINS-1:0];
            if (wrAdis) analog_input_disable_upper <= regWdata[NPINS-1:0];
            if (wrStby) standby_pin_state_select <= regWdata[STBY_SEL_BIT];
        end
    end

    // ----------------------------------------
    // pin input synchroniser
    // ----------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            pinMeta <= PIN_RESET;
            pinSync <= PIN_RESET;
        end else begin
            pinMeta <= pinIn;
            pinSync <= pinMeta;
        end
    end

    // ----------------------------------------
    // pin drive
    // ----------------------------------------
    wire              forceHiz  = standby_pin_state_select && stopOrWatch;
    wire [NPINS-1:0]  driveEn   = (port7_direction | periphOe) & {NPINS{~forceHiz}};
    wire [NPINS-1:0]  driveVal  = (periphOe & periphOut) | (~periphOe & port7_data_latch);
    // analog-shared pins read low until software enables digital input
    wire [NPINS-1:0]  inputOpen = ~analogShared | analog_input_disable_upper;
    wire [NPINS-1:0]  unblocked = {NPINS{~forceHiz}} | keepInputAwake;
    wire [NPINS-1:0]  pinLevel  = pinSync & inputOpen & unblocked;

    assign pinOut   = driveVal;
    assign pinOe    = driveEn;
    assign pullupOn = port7_pullup_enable & ~(driveEn & ~driveVal);
    assign periphIn = pinLevel;

    // ----------------------------------------
    // read path
    // ----------------------------------------
    // RMW reads return the latch; otherwise port outputs the latch, peripheral-driven and input pins the level
    wire [NPINS-1:0]  portOut   = port7_direction & ~periphOe;
    wire [NPINS-1:0]  dataView  = regRmw ? port7_data_latch :
                                  (portOut & port7_data_latch) | (~portOut & pinLevel);
    logic [DW-1:0]    next_rdata;

    always_comb begin
        next_rdata = RD_UNMAPPED;
        case (regAddr)
            ADDR_DATA:       next_rdata = {{(DW-NPINS){1'b0}}, dataView};
            ADDR_DIR:        next_rdata = {{(DW-NPINS){1'b0}}, port7_direction};
            ADDR_PULLUP:     next_rdata = {{(DW-NPINS){1'b0}}, port7_pullup_enable};
            ADDR_ANALOG_DIS: next_rdata = {{(DW-NPINS){1'b0}}, analog_input_disable_upper};
            ADDR_STANDBY:    next_rdata = {{(DW-1){1'b0}}, standby_pin_state_select};
            default:         next_rdata = RD_UNMAPPED;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) regRdata <= RD_UNMAPPED;
        else if (regRead) regRdata <= next_rdata;
        else regRdata <= RD_UNMAPPED;
    end
endmodule : gpio_port_pin_logic

/* File: src/gpio_port_pkg.sv */
// Purpose: constants for the port 7 pin logic
// Assumes: plain register port, 8-bit data, one clock
// Notes: register offsets chosen locally
package gpio_port_pkg;
    localparam int    NPINS             = 3;
    localparam int    DW                = 8;
    localparam int    AW                = 4;
    localparam [3:0]  ADDR_DATA         = 4'h0;
    localparam [3:0]  ADDR_DIR          = 4'h1;
    localparam [3:0]  ADDR_PULLUP       = 4'h2;
    localparam [3:0]  ADDR_ANALOG_DIS   = 4'h3;
    localparam [3:0]  ADDR_STANDBY      = 4'h4;
    localparam int    STBY_SEL_BIT      = 0;
    localparam [2:0]  PIN_RESET         = 3'h0;
    localparam [7:0]  RD_UNMAPPED       = 8'h00;
endpackage : gpio_port_pkg

/* File: tb/gpio_port_pin_logic_props.sv */
// Purpose: port checks for port 7 pin logic
// Assumes: bound in by name
// Notes: write data followed two cycles deep only
`timescale 1ns/100ps
module gpio_port_pin_logic_props import gpio_port_pkg::*; (
    input wire logic mclk, arst_n, regWrite, regRead, regRmw, stopOrWatch,
    input wire logic [AW-1:0] regAddr,
    input wire logic [DW-1:0] regWdata, regRdata,
    input wire logic [NPINS-1:0] pinOut, pinOe, pullupOn, periphOe, periphOut, periphIn, keepInputAwake
);
    logic [2:0] w1, w2;
    logic       stbySel;
    // shadow of the standby select bit, so the hold check only covers a select that stays 0
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) stbySel <= 1'b0;
        else if (regWrite && regAddr == ADDR_STANDBY) stbySel <= regWdata[0];
    end
    always_ff @(posedge mclk) begin
        w1 <= regWdata[2:0];
        w2 <= w1;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!arst_n);
    a_latch_on_pins: assert property (regWrite && regAddr == ADDR_DATA |=>
        ((pinOut ^ w1) & pinOe & ~periphOe) == 3'h0) else $error("pin differs from latch");
    a_dir_sets_drive: assert property (regWrite && regAddr == ADDR_DIR && !stopOrWatch ##1 !stopOrWatch |->
        pinOe == (w1 | periphOe)) else $error("drive enable wrong");
    a_periph_routes: assert property (!stopOrWatch |->
        (periphOe & ~pinOe) == 3'h0 && ((pinOut ^ periphOut) & periphOe) == 3'h0) else $error("peripheral not routed");
    a_upper_read_zero: assert property (regRead |=> regRdata[7:3] == 5'h00) else $error("upper bits set");
    a_rmw_gets_latch: assert property (regWrite && regAddr == ADDR_DATA ##1 regRead && regRmw &&
        regAddr == ADDR_DATA |=> regRdata[2:0] == w2) else $error("rmw read not latch");
    a_pullup_low_off: assert property ((pinOe & ~pinOut & pullupOn) == 3'h0) else $error("pull-up on low pin");
    a_standby_gates: assert property (regWrite && regAddr == ADDR_STANDBY && regWdata[0] && stopOrWatch
        ##1 stopOrWatch |-> ((pinOe | periphIn) & ~keepInputAwake) == 3'h0) else $error("standby not gated");
    a_standby_holds: assert property (!stbySel && regWrite && regAddr == ADDR_STANDBY && !regWdata[0] && stopOrWatch
        |=> $stable(pinOe) && $stable(pinOut)) else $error("standby changed pins");
endmodule : gpio_port_pin_logic_props

/* File: tb/gpio_pin_model.sv */
// Purpose: wire level seen at the three pins
// Assumes: our drive beats outside source and pull-up
// Notes: unpulled floating pin reads inverse of drive
`timescale 1ns/100ps
module gpio_pin_model (
    input  wire logic [2:0] pinOut, pinOe, pullupOn, extEn, extVal,
    output logic      [2:0] level
);
    assign level = (pinOe & pinOut) | (~pinOe & extEn & extVal) | (~pinOe & ~extEn & (pullupOn | ~pinOut));
endmodule : gpio_pin_model

/* File: tb/gpio_port_pin_logic_tb.sv */
// Purpose: self-checking bench for port 7 pin logic
// Assumes: pin 2 analog shared, pin 0 kept awake
// Notes: pin reads lag the wire by two-stage sync
`timescale 1ns/100ps
module gpio_port_pin_logic_tb;
    import gpio_port_pkg::*;
    logic mclk = 0, arst_n = 0, regWrite = 0, regRead = 0, regRmw = 0, stopOrWatch = 0;
    logic [AW-1:0] regAddr = '0;
    logic [DW-1:0] regWdata = '0, regRdata;
    logic [2:0] pinIn, pinOut, pinOe, pullupOn, periphIn, periphOe = 0, periphOut = 0, extEn = 7, extVal = 5;
    int err_count = 0, checks = 0, cycles = 0;
    gpio_port_pin_logic u_dut (.*, .analogShared(3'h4), .keepInputAwake(3'h1));
    gpio_pin_model u_pins (.pinOut, .pinOe, .pullupOn, .extEn, .extVal, .level(pinIn));
    initial forever #5 mclk = ~mclk;
    always @(posedge mclk) if (++cycles == 2000) begin err_count++; tally_and_finish(); end
    task chk(input logic [7:0] seen, want);
        checks++;
        if (seen !== want) begin err_count++; $display("unexpected %0t: %h %h", $time, seen, want); end
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk) {regRead, regWrite, regAddr, regWdata} <= {2'b01, a, d};
    endtask
    task rd(input logic [3:0] a, input logic rmw, input logic [7:0] want);
        @(posedge mclk) {regRead, regRmw, regWrite, regAddr} <= {1'b1, rmw, 1'b0, a};
        @(posedge mclk) {regRead, regRmw} <= 2'b00;
        #1 chk(regRdata, want);
    endtask
    task idle(input int n);
        repeat (n) @(posedge mclk) {regRead, regWrite} <= 2'b00;
        #1;
    endtask
    task t_reset;
        rd(ADDR_DIR, 0, 8'h00);
        rd(ADDR_DATA, 0, 8'h01);
        wr(ADDR_ANALOG_DIS, 8'h07);
        idle(3);
        rd(ADDR_DATA, 0, 8'h05);
    endtask
    task t_out;
        wr(ADDR_DIR, 8'hff);
        wr(ADDR_DATA, 8'hfa);
        idle(1);
        chk({pinOe, pinOut}, 8'h3a);
        rd(ADDR_DIR, 0, 8'h07);
        rd(ADDR_DATA, 0, 8'h02);
    endtask
    task t_in;
        wr(ADDR_DIR, 8'h00);
        wr(ADDR_DATA, 8'h03);
        rd(ADDR_DATA, 1, 8'h03);
        idle(3);
        chk({5'h0, pinOe}, 8'h00);
        rd(ADDR_DATA, 0, 8'h05);
    endtask
    task t_periph;
        wr(ADDR_DIR, 8'h07);
        periphOe <= 3'h1;
        idle(3);
        rd(ADDR_DATA, 0, 8'h02);
        @(posedge mclk) periphOe <= 3'h0;
        wr(ADDR_PULLUP, 8'h07);
        idle(1);
        chk({5'h0, pullupOn}, 8'h03);
    endtask
    task t_standby;
        @(posedge mclk) stopOrWatch <= 1'b1;
        wr(ADDR_STANDBY, 8'h00);
        idle(3);
        chk({pinOe, pinOut}, 8'h3b);
        wr(ADDR_STANDBY, 8'h01);
        idle(3);
        chk({pinOe, periphIn}, 8'h01);
        rd(4'hf, 0, 8'h00);
    endtask
    task tally_and_finish;
        if (err_count == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        arst_n <= 1'b1;
        t_reset();
        t_out();
        t_in();
        t_periph();
        t_standby();
        tally_and_finish();
    end
endmodule : gpio_port_pin_logic_tb
bind gpio_port_pin_logic gpio_port_pin_logic_props u_props (.*);
